// ==== rtl/cta_clamp_timer.sv ====
// Down-counter that holds one clamp on for its programmed cycle count
`timescale 1ns/100ps
module cta_clamp_timer
    import cta_pkg::*;
#(
    parameter int CNT_W = ON_TIME_W
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic start_i,
    input wire logic [CNT_W-1:0] on_time_i,
    output logic busy_o,
    output logic active_o
);

    // Width check
    if (CNT_W < 1 || CNT_W > 16) begin : g_bad_width
        $error("cta_clamp_timer: CNT_W out of range");
    end

    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic active_reg;
    logic active_next;

    // Load on start while idle, else count down to zero
    always_comb begin
        count_next = count_reg;
        if (count_reg != '0) begin
            count_next = count_reg - 1'b1;
        end else if (start_i) begin
            count_next = on_time_i;
        end
        active_next = (count_next != '0);
    end

    // State registers
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count_reg <= '0;
            active_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            active_reg <= active_next;
        end
    end

    assign busy_o = (count_reg != '0);
    assign active_o = active_reg;

endmodule : cta_clamp_timer

// ==== rtl/cta_clamp_timing_regs.sv ====
// Clamp, timing, trim and aux result registers with clamp sequencer
`timescale 1ns/100ps
module cta_clamp_timing_regs
    import cta_pkg::*;
#(
    parameter int NUM_AUX = AUX_COUNT,
    parameter int NUM_CLAMP = CLAMPS_PER_BANK
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire cta_reg_req_t reg_req_i,
    output logic [DATA_W-1:0] rd_data_o,
    output logic rd_valid_o,
    input wire logic sync_in_i,
    input wire logic aux_mode_i,
    input wire logic [NUM_AUX-1:0] aux_valid_i,
    input wire logic [NUM_AUX*DATA_W-1:0] aux_data_i,
    output logic [NUM_CLAMP-1:0] fine_clamp_on_o,
    output logic [NUM_CLAMP-1:0] fine_clamp_dir_o,
    output logic [NUM_CLAMP-1:0] coarse_clamp_on_o,
    output logic [NUM_CLAMP-1:0] coarse_clamp_dir_o,
    output cta_timing_t timing_o,
    output logic [2:0] reference_trim_value_o
);

    // Parameter checks: the subaddress map holds exactly these counts
    if (NUM_AUX != AUX_COUNT) begin : g_bad_aux
        $error("cta_clamp_timing_regs: NUM_AUX must be 8");
    end
    if (NUM_CLAMP != CLAMPS_PER_BANK) begin : g_bad_clamp
        $error("cta_clamp_timing_regs: NUM_CLAMP must be 3");
    end
    if (CLAMP1_COARSE_LSB + ON_TIME_W > CLAMP1_SYNC_EN_BIT) begin : g_bad_field
        $error("cta_clamp_timing_regs: on-time fields overlap sync bit");
    end

    localparam int NCL = 2 * CLAMPS_PER_BANK;

    // True when the subaddress falls in the aux result window
    function automatic logic is_aux(input logic [4:0] a);
        is_aux = (a >= ADDR_AUX_BASE) &&
                 (a < (ADDR_AUX_BASE + 5'(AUX_COUNT)));
    endfunction : is_aux

    // Aux register index of a subaddress in the window
    function automatic logic [2:0] aux_index(input logic [4:0] a);
        logic [4:0] d;
        d = a - ADDR_AUX_BASE;
        aux_index = d[2:0];
    endfunction : aux_index

    // On/off bit of clamp k in a clamp bank register
    function automatic logic on_bit(input logic [7:0] r, input int k);
        on_bit = r[CLAMP_ON_BIT0 + 2 * k];
    endfunction : on_bit

    // Direction bit of clamp k in a clamp bank register
    function automatic logic dir_bit(input logic [7:0] r, input int k);
        dir_bit = r[CLAMP_DIR_BIT0 + 2 * k];
    endfunction : dir_bit

    //------------------------------------------------------------------
    // Control registers
    logic [7:0] mode3_reg;
    logic [7:0] mode3_next;
    logic [7:0] clamp1_reg;
    logic [7:0] clamp1_next;
    logic [7:0] clamp2_reg;
    logic [7:0] clamp2_next;
    logic [7:0] clamp3_reg;
    logic [7:0] clamp3_next;
    logic [7:0] timing_reg;
    logic [7:0] timing_next;
    logic [7:0] trim_reg;
    logic [7:0] trim_next;
    logic wr_en;
    logic rd_en;

    assign wr_en = reg_req_i.wr;
    assign rd_en = reg_req_i.rd;

    // Write decode; reserved bits are masked off on the way in
    always_comb begin
        mode3_next = mode3_reg;
        clamp1_next = clamp1_reg;
        clamp2_next = clamp2_reg;
        clamp3_next = clamp3_reg;
        timing_next = timing_reg;
        trim_next = trim_reg;
        if (wr_en) begin
            case (reg_req_i.register_subaddress)
                ADDR_MODE3: begin
                    mode3_next = reg_req_i.wdata & MODE3_MASK;
                end
                ADDR_CLAMP1: begin
                    clamp1_next = reg_req_i.wdata & CLAMP1_MASK;
                end
                ADDR_CLAMP2: begin
                    clamp2_next = reg_req_i.wdata & CLAMP_MASK;
                end
                ADDR_CLAMP3: begin
                    clamp3_next = reg_req_i.wdata & CLAMP_MASK;
                end
                ADDR_TIMING: begin
                    timing_next = reg_req_i.wdata & TIMING_MASK;
                end
                ADDR_TRIM: begin
                    trim_next = reg_req_i.wdata & TRIM_MASK;
                end
                default: begin
                    // Aux and unmapped writes change nothing
                    mode3_next = mode3_reg;
                end
            endcase
        end
    end

    // Control register flops
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode3_reg <= MODE3_RST;
            clamp1_reg <= CLAMP1_RST;
            clamp2_reg <= CLAMP2_RST;
            clamp3_reg <= CLAMP3_RST;
            timing_reg <= TIMING_RST;
            trim_reg <= TRIM_RST;
        end else begin
            mode3_reg <= mode3_next;
            clamp1_reg <= clamp1_next;
            clamp2_reg <= clamp2_next;
            clamp3_reg <= clamp3_next;
            timing_reg <= timing_next;
            trim_reg <= trim_next;
        end
    end

    //------------------------------------------------------------------
    // Aux result registers
    logic [DATA_W-1:0] aux_reg [AUX_COUNT];
    logic [DATA_W-1:0] aux_next [AUX_COUNT];

    // Each channel loads its own latest conversion while in aux mode
    always_comb begin
        for (int n = 0; n < AUX_COUNT; n++) begin
            aux_next[n] = aux_reg[n];
            if (aux_mode_i && aux_valid_i[n]) begin
                aux_next[n] = aux_data_i[n*DATA_W +: DATA_W];
            end
        end
    end

    // Aux result flops
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int n = 0; n < AUX_COUNT; n++) begin
                aux_reg[n] <= AUX_RST;
            end
        end else begin
            for (int n = 0; n < AUX_COUNT; n++) begin
                aux_reg[n] <= aux_next[n];
            end
        end
    end

    //------------------------------------------------------------------
    // Read port
    logic [DATA_W-1:0] rd_data_reg;
    logic [DATA_W-1:0] rd_data_next;
    logic rd_valid_reg;
    logic rd_valid_next;

    // Read mux, answer one cycle after the request; unmapped reads zero
    always_comb begin
        rd_valid_next = rd_en;
        rd_data_next = rd_data_reg;
        if (rd_en) begin
            case (reg_req_i.register_subaddress)
                ADDR_MODE3: rd_data_next = mode3_reg;
                ADDR_CLAMP1: rd_data_next = clamp1_reg;
                ADDR_CLAMP2: rd_data_next = clamp2_reg;
                ADDR_CLAMP3: rd_data_next = clamp3_reg;
                ADDR_TIMING: rd_data_next = timing_reg;
                ADDR_TRIM: rd_data_next = trim_reg;
                default: begin
                    if (is_aux(reg_req_i.register_subaddress)) begin
                        rd_data_next =
                            aux_reg[aux_index(reg_req_i.register_subaddress)];
                    end else begin
                        rd_data_next = 8'h00;
                    end
                end
            endcase
        end
    end

    // Read flops
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_data_reg <= 8'h00;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_data_reg <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
        end
    end

    assign rd_data_o = rd_data_reg;
    assign rd_valid_o = rd_valid_reg;

    //------------------------------------------------------------------
    // Clamp sequencer; index 0..2 fine clamps, 3..5 coarse clamps
    logic sync_prev_reg;
    logic sync_prev_next;
    logic [NCL-1:0] on_prev_reg;
    logic [NCL-1:0] on_prev_next;
    logic [NCL-1:0] armed_reg;
    logic [NCL-1:0] armed_next;
    logic [NCL-1:0] on_bits;
    logic [NCL-1:0] start;
    logic [NCL-1:0] busy;
    logic [NCL-1:0] active;
    logic sync_edge;
    logic sync_mode;
    logic sync_pol;

    assign sync_mode = clamp1_reg[CLAMP1_SYNC_EN_BIT];
    assign sync_pol = mode3_reg[MODE3_SYNC_POL_BIT];

    // Gather on/off bits of both banks
    always_comb begin
        for (int k = 0; k < CLAMPS_PER_BANK; k++) begin
            on_bits[k] = on_bit(clamp2_reg, k);
            on_bits[k + CLAMPS_PER_BANK] = on_bit(clamp3_reg, k);
        end
    end

    // Sync edge: falling for low pulses, rising for high pulses
    always_comb begin
        sync_prev_next = sync_in_i;
        if (sync_pol) begin
            sync_edge = sync_in_i && !sync_prev_reg;
        end else begin
            sync_edge = !sync_in_i && sync_prev_reg;
        end
    end

    // Trigger logic per clamp
    always_comb begin
        on_prev_next = on_bits;
        armed_next = armed_reg;
        start = '0;
        for (int k = 0; k < NCL; k++) begin
            if (!sync_mode) begin
                armed_next[k] = 1'b0;
                // Start on the bit's rising edge, even while running; the timer ignores it then
                start[k] = on_bits[k] && !on_prev_reg[k];
            end else begin
                if (on_bits[k] && !on_prev_reg[k] && !busy[k]) begin
                    armed_next[k] = 1'b1;
                end
                if (armed_reg[k] && sync_edge && !busy[k]) begin
                    start[k] = 1'b1;
                    armed_next[k] = 1'b0;
                end
            end
        end
    end

    // Sequencer flops
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync_prev_reg <= 1'b0;
            on_prev_reg <= '0;
            armed_reg <= '0;
        end else begin
            sync_prev_reg <= sync_prev_next;
            on_prev_reg <= on_prev_next;
            armed_reg <= armed_next;
        end
    end

    // One timer per clamp, fine ones on the fine on-time field
    for (genvar g = 0; g < NCL; g++) begin : g_timer
        localparam int LSB = (g < CLAMPS_PER_BANK) ?
                             CLAMP1_FINE_LSB : CLAMP1_COARSE_LSB;
        cta_clamp_timer #(
            .CNT_W(ON_TIME_W)
        ) u_timer (
            .core_clk_i(core_clk_i),
            .rstn_i(rstn_i),
            .start_i(start[g]),
            .on_time_i(clamp1_reg[LSB +: ON_TIME_W]),
            .busy_o(busy[g]),
            .active_o(active[g])
        );
    end

    // Clamp on and direction outputs
    always_comb begin
        for (int k = 0; k < CLAMPS_PER_BANK; k++) begin
            fine_clamp_on_o[k] = active[k];
            coarse_clamp_on_o[k] = active[k + CLAMPS_PER_BANK];
            fine_clamp_dir_o[k] = dir_bit(clamp2_reg, k);
            coarse_clamp_dir_o[k] = dir_bit(clamp3_reg, k);
        end
    end

    //------------------------------------------------------------------
    // Timing and trim controls to the analog side
    always_comb begin
        timing_o.oscillator_enable = timing_reg[TIMING_OSC_BIT];
        timing_o.bias_double = timing_reg[TIMING_BIAS_BIT];
        timing_o.duty_equalizer_enable = timing_reg[TIMING_EQ_BIT];
        timing_o.core_clock_delay =
            timing_reg[TIMING_DELAY_LSB +: 2];
    end

    // Reference trim select straight from its register
    always_comb begin
        reference_trim_value_o = trim_reg[TRIM_VALUE_LSB +: 3];
    end

endmodule : cta_clamp_timing_regs

// ==== rtl/cta_pkg.sv ====
// Package of constants and types for the clamp, timing and aux registers
package cta_pkg;

    // Register port widths, counts and on-time field width
    localparam int SUBADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int AUX_COUNT = 8;
    localparam int CLAMPS_PER_BANK = 3;
    localparam int ON_TIME_W = 3;

    // Register subaddresses
    localparam logic [4:0] ADDR_MODE3 = 5'h03;
    localparam logic [4:0] ADDR_CLAMP1 = 5'h07;
    localparam logic [4:0] ADDR_CLAMP2 = 5'h08;
    localparam logic [4:0] ADDR_CLAMP3 = 5'h09;
    localparam logic [4:0] ADDR_TIMING = 5'h0A;
    localparam logic [4:0] ADDR_TRIM = 5'h0B;
    localparam logic [4:0] ADDR_AUX_BASE = 5'h10;

    // Field positions
    localparam int MODE3_SYNC_POL_BIT = 5;
    localparam int CLAMP1_FINE_LSB = 0;
    localparam int CLAMP1_COARSE_LSB = 3;
    localparam int CLAMP1_SYNC_EN_BIT = 6;
    localparam int CLAMP_DIR_BIT0 = 0;
    localparam int CLAMP_ON_BIT0 = 1;
    localparam int TIMING_OSC_BIT = 0;
    localparam int TIMING_BIAS_BIT = 1;
    localparam int TIMING_EQ_BIT = 3;
    localparam int TIMING_DELAY_LSB = 5;
    localparam int TRIM_ONE_BIT = 0;
    localparam int TRIM_VALUE_LSB = 4;

    // Storable bits; reserved bits are not kept and read as zero
    localparam logic [7:0] MODE3_MASK = 8'h20;
    localparam logic [7:0] CLAMP1_MASK = 8'h7F;
    localparam logic [7:0] CLAMP_MASK = 8'h3F;
    localparam logic [7:0] TIMING_MASK = 8'h6B;
    localparam logic [7:0] TRIM_MASK = 8'h71;

    // Reset values
    localparam logic [7:0] MODE3_RST = 8'h00;
    localparam logic [7:0] CLAMP1_RST = 8'h00;
    localparam logic [7:0] CLAMP2_RST = 8'h00;
    localparam logic [7:0] CLAMP3_RST = 8'h00;
    localparam logic [7:0] TIMING_RST = 8'h01;
    localparam logic [7:0] TRIM_RST = 8'h01;
    localparam logic [7:0] AUX_RST = 8'h00;

    // Register access request from the serial front end
    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] register_subaddress;
        logic [7:0] wdata;
    } cta_reg_req_t;

    // Clock and bias controls to the analog side
    typedef struct packed {
        logic [1:0] core_clock_delay;
        logic duty_equalizer_enable;
        logic bias_double;
        logic oscillator_enable;
    } cta_timing_t;

endpackage : cta_pkg

// ==== tb/cta_clamp_timing_regs_properties.sv ====
// Checker of port behaviour for the clamp, timing and aux register bank
`timescale 1ns/100ps
module cta_regs_props
    import cta_pkg::*;
#(
    parameter int NUM_AUX = AUX_COUNT,
    parameter int NUM_CLAMP = CLAMPS_PER_BANK
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire cta_reg_req_t reg_req_i,
    input wire logic [DATA_W-1:0] rd_data_o,
    input wire logic rd_valid_o,
    input wire logic sync_in_i,
    input wire logic aux_mode_i,
    input wire logic [NUM_AUX-1:0] aux_valid_i,
    input wire logic [NUM_AUX*DATA_W-1:0] aux_data_i,
    input wire logic [NUM_CLAMP-1:0] fine_clamp_on_o,
    input wire logic [NUM_CLAMP-1:0] coarse_clamp_on_o,
    input wire logic [NUM_CLAMP-1:0] coarse_clamp_dir_o,
    input wire cta_timing_t timing_o,
    input wire logic [2:0] reference_trim_value_o
);
    logic [7:0] cfg_reg, cfg_next, wd_reg, wd_next, wdat;
    logic pol_reg, pol_next, wr;
    logic [4:0] frun_reg, frun_next, crun_reg, crun_next, addr;
    assign addr = reg_req_i.register_subaddress;
    assign wdat = reg_req_i.wdata;
    assign wr = reg_req_i.wr;

    // Shadow of clamp setup and polarity, run lengths, last write data
    always_comb begin
        cfg_next = (wr && addr == ADDR_CLAMP1) ? wdat : cfg_reg;
        pol_next = (wr && addr == ADDR_MODE3) ? wdat[5] : pol_reg;
        frun_next = fine_clamp_on_o[0] ? frun_reg + 5'h01 : 5'h00;
        crun_next = coarse_clamp_on_o[2] ? crun_reg + 5'h01 : 5'h00;
        wd_next = wdat;
    end

    // Helper registers
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            {cfg_reg, pol_reg, frun_reg, crun_reg, wd_reg} <= '0;
        end else begin
            {cfg_reg, pol_reg, frun_reg, crun_reg, wd_reg} <=
                {cfg_next, pol_next, frun_next, crun_next, wd_next};
        end
    end

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rstn_i);

    // Aux load followed by a read of channel zero
    sequence s_aux0_load;
        aux_mode_i && aux_valid_i[0];
    endsequence
    sequence s_aux0_read;
        reg_req_i.rd && addr == ADDR_AUX_BASE && !aux_valid_i[0];
    endsequence

    a_rd_valid_follows: assert property (
        reg_req_i.rd |=> rd_valid_o)
        else $error("read strobe not answered one cycle later");
    a_rd_valid_only: assert property (
        !reg_req_i.rd |=> !rd_valid_o)
        else $error("read valid without a read strobe");
    a_unmapped_zero: assert property (reg_req_i.rd && addr == 5'h1F
        |=> rd_data_o == 8'h00) else $error("unmapped read not zero");
    a_aux_load_read: assert property (s_aux0_load ##1 s_aux0_read
        |=> rd_data_o == $past(aux_data_i[7:0], 2))
        else $error("aux channel zero read differs from last load");
    a_timing_write: assert property (
        wr && addr == ADDR_TIMING
        |=> timing_o == {wd_reg[6:5], wd_reg[3], wd_reg[1:0]})
        else $error("timing outputs do not follow the write");
    a_trim_write: assert property (wr && addr == ADDR_TRIM
        |=> reference_trim_value_o == wd_reg[6:4])
        else $error("trim output does not follow the write");
    a_coarse_dir: assert property (wr && addr == ADDR_CLAMP3
        |=> coarse_clamp_dir_o == {wd_reg[4], wd_reg[2], wd_reg[0]})
        else $error("coarse direction outputs do not follow the write");
    a_coarse_width: assert property (
        $fell(coarse_clamp_on_o[2])
        |-> crun_reg == {2'b00, cfg_reg[5:3]})
        else $error("coarse clamp two on for wrong cycle count");
    a_fine_width: assert property (
        $fell(fine_clamp_on_o[0])
        |-> frun_reg == {2'b00, cfg_reg[2:0]})
        else $error("fine clamp zero on for wrong cycle count");
    a_sync_start: assert property (
        $rose(coarse_clamp_on_o[2]) && cfg_reg[6]
        |-> $past(sync_in_i) == pol_reg && $past(sync_in_i, 2) != pol_reg)
        else $error("coarse clamp two rose without an active sync edge");
endmodule : cta_regs_props

bind cta_clamp_timing_regs cta_regs_props #(
    .NUM_AUX(NUM_AUX),
    .NUM_CLAMP(NUM_CLAMP)
) u_props (
    .core_clk_i, .rstn_i, .reg_req_i, .rd_data_o, .rd_valid_o,
    .sync_in_i, .aux_mode_i, .aux_valid_i, .aux_data_i,
    .fine_clamp_on_o, .coarse_clamp_on_o, .coarse_clamp_dir_o,
    .timing_o, .reference_trim_value_o
);

// ==== tb/cta_clamp_timing_regs_tb_top.sv ====
// Testbench top for the clamp, timing and aux register bank
`timescale 1ns/100ps
module cta_clamp_timing_regs_tb_top
    import cta_pkg::*;
;
    logic core_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic sync_in_i = 1'b0;
    logic aux_mode_i = 1'b0;
    logic [7:0] aux_valid_i = 8'h00;
    logic [63:0] aux_data_i = 64'h0;
    cta_reg_req_t reg_req_i;
    logic [7:0] rd_data_o;
    logic rd_valid_o;
    logic [2:0] fine_clamp_on_o, fine_clamp_dir_o, reference_trim_value_o;
    logic [2:0] coarse_clamp_on_o, coarse_clamp_dir_o;
    logic [5:0] clamps;
    cta_timing_t timing_o;
    int n_fail = 0;
    int checks = 0;
    assign clamps = {coarse_clamp_on_o, fine_clamp_on_o};

    always #12.5 core_clk_i = ~core_clk_i;

    cta_clamp_timing_regs u_dut (
        .core_clk_i, .rstn_i, .reg_req_i, .rd_data_o, .rd_valid_o,
        .sync_in_i, .aux_mode_i, .aux_valid_i, .aux_data_i,
        .fine_clamp_on_o, .fine_clamp_dir_o, .coarse_clamp_on_o,
        .coarse_clamp_dir_o, .timing_o, .reference_trim_value_o
    );

    cta_host_model u_host (
        .core_clk_i, .rd_valid_i(rd_valid_o), .rd_data_i(rd_data_o),
        .req_o(reg_req_i)
    );

    // Comparison and verdict
    task automatic check(input string what, input logic [7:0] got, exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    // Waits for one clamp to rise, then counts its cycles high
    task automatic measure(input int idx, output int n);
        int k;
        n = 0;
        for (k = 0; k < 20 && clamps[idx] !== 1'b1; k++) @(posedge core_clk_i);
        while (clamps[idx] === 1'b1 && n < 20) begin
            n++;
            @(posedge core_clk_i);
        end
    endtask : measure

    // Main sequence
    initial begin
        int i, c, f, got;
        logic [7:0] d, q;
        logic [63:0] ad;
        logic p;
        void'($urandom(3));
        repeat (16) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        @(posedge core_clk_i);
        // Reset values, unmapped place last
        for (i = 0; i < 8; i++) begin
            u_host.hr(5'({5'h1F, 5'h10, 5'h0B, 5'h0A, 5'h09, 5'h08, 5'h07,
                5'h03} >> (5 * i)), q);
            check("reset value", q, 8'(64'h0000010100000000 >> (8 * i)));
        end
        check("timing reset", {3'b000, timing_o}, 8'h01);
        // Every delay code with random timing and trim bits
        for (i = 0; i < 4; i++) begin
            d = 8'(i << 5) | 8'($urandom & 32'h0B);
            u_host.hw(ADDR_TIMING, d);
            check("timing out", {3'b000, timing_o}, {d[6:5], d[3], d[1:0]});
            u_host.hr(ADDR_TIMING, q);
            check("timing readback", q, d);
            d = 8'($urandom & 32'h70) | 8'h01;
            u_host.hw(ADDR_TRIM, d);
            check("trim out", {5'h00, reference_trim_value_o}, {5'h00, d[6:4]});
            u_host.hr(ADDR_TRIM, q);
            check("trim readback", q, d);
        end
        // Immediate clamps: coarse on-times zero, full and random, fine on-times random
        for (i = 0; i < 3; i++) begin
            c = (i == 0) ? 0 : (i == 1) ? 7 : 5 + $urandom % 2;
            f = 1 + $urandom % 7;
            u_host.hw(ADDR_CLAMP1, 8'((c << 3) | f));
            d = 8'h2A | 8'($urandom & 32'h15);
            u_host.hw(ADDR_CLAMP2, 8'h00);
            u_host.hw(ADDR_CLAMP2, d);
            measure(i, got);
            check("fine width", 8'(got), 8'(f));
            q = {5'h00, d[4], d[2], d[0]};
            check("fine dir", 8'(fine_clamp_dir_o), q);
            u_host.hw(ADDR_CLAMP3, 8'h10);
            fork
                measure(5, got);
                begin
                    u_host.hw(ADDR_CLAMP3, 8'h30);
                    u_host.hw(ADDR_CLAMP3, 8'h10); // Cleared first
                    u_host.hw(ADDR_CLAMP3, 8'h30);
                end
            join
            check("coarse2 width", 8'(got), 8'(c));
            check("coarse2 dir", {7'h00, coarse_clamp_dir_o[2]}, 8'h01);
            u_host.hw(ADDR_CLAMP3, 8'h30);
            measure(5, got);
            check("coarse2 no clear", 8'(got), 8'h00);
        end
        // Sync-triggered clamp for both polarities
        for (i = 0; i < 2; i++) begin
            p = i[0];
            sync_in_i <= !p;
            u_host.hw(ADDR_MODE3, {2'b00, p, 5'h00});
            u_host.hw(ADDR_CLAMP1, 8'h70);
            u_host.hw(ADDR_CLAMP3, 8'h10);
            u_host.hw(ADDR_CLAMP3, 8'h30);
            measure(5, got);
            check("coarse2 before sync", 8'(got), 8'h00);
            sync_in_i <= p;
            measure(5, got);
            check("coarse2 after sync", 8'(got), 8'h06);
            sync_in_i <= !p;
            u_host.hw(ADDR_CLAMP1, 8'h00);
        end
        // Aux loads, write attempt, loads ignored out of aux mode
        ad = {$urandom, $urandom};
        aux_mode_i <= 1'b1;
        aux_data_i <= ad;
        aux_valid_i <= 8'hFF;
        @(posedge core_clk_i);
        aux_valid_i <= 8'h00;
        for (i = 0; i < 8; i++) begin
            u_host.hr(5'(ADDR_AUX_BASE + i), q);
            check("aux result", q, ad[8*i +: 8]);
        end
        u_host.hw(ADDR_AUX_BASE, ~ad[7:0]);
        u_host.hr(ADDR_AUX_BASE, q);
        check("aux read only", q, ad[7:0]);
        aux_mode_i <= 1'b0;
        aux_data_i <= ~ad;
        aux_valid_i <= 8'hFF;
        @(posedge core_clk_i);
        aux_valid_i <= 8'h00;
        u_host.hr(5'h17, q);
        check("aux out of mode", q, ad[63:56]);
        wrap_up();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (5000) @(posedge core_clk_i);
        n_fail++;
        wrap_up();
    end
endmodule : cta_clamp_timing_regs_tb_top

// ==== tb/cta_host_model.sv ====
// Host model issuing register writes and reads at the subaddress port
`timescale 1ns/100ps
module cta_host_model
    import cta_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rd_valid_i,
    input wire logic [DATA_W-1:0] rd_data_i,
    output cta_reg_req_t req_o
);
    initial req_o = '0;

    // Reserved clamp, timing and trim bits go out as zero, trim bit zero always one; other addresses pass data unchanged
    function automatic logic [7:0] legal(input logic [4:0] a,
                                         input logic [7:0] d);
        case (a)
            ADDR_CLAMP1: legal = d & CLAMP1_MASK;
            ADDR_CLAMP2, ADDR_CLAMP3: legal = d & CLAMP_MASK;
            ADDR_TIMING: legal = d & TIMING_MASK;
            ADDR_TRIM: legal = (d & TRIM_MASK) | 8'h01;
            default: legal = d;
        endcase
    endfunction : legal

    // Write: held one edge, then released with inverted lines
    task automatic hw(input logic [4:0] a, input logic [7:0] d);
        req_o <= '{1'b1, 1'b0, a, legal(a, d)};
        @(posedge core_clk_i);
        req_o <= '{1'b0, 1'b0, ~a, ~legal(a, d)};
        @(posedge core_clk_i);
    endtask : hw

    // Read: answer taken one cycle after the strobe
    task automatic hr(input logic [4:0] a, output logic [7:0] d);
        req_o <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge core_clk_i);
        req_o <= '{1'b0, 1'b0, ~a, 8'hFF};
        @(posedge core_clk_i);
        d = (rd_valid_i === 1'b1) ? rd_data_i : 8'hXX;
    endtask : hr
endmodule : cta_host_model
